// ### include/bmod_pkg.sv
package bmod_pkg;

    // Opcode fields
    localparam logic [5:0]  OP_OR_FILE    = 6'h04;
    localparam logic [5:0]  OP_COPY_FILE  = 6'h14;
    localparam logic [3:0]  OP_COPY_FIRST = 4'hC;
    localparam logic [3:0]  OP_SECOND     = 4'hF;
    localparam logic [7:0]  OP_LOAD_PTR   = 8'hEE;
    localparam logic [15:0] OP_NOP        = 16'h0000;

    // Address map
    localparam logic [11:0] ACC_ADDR      = 12'h0FE8;
    localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;
    localparam logic [7:0]  INDEX_LIMIT   = 8'h5F;
    localparam logic [3:0]  ACCESS_HIGH   = 4'hF;
    localparam int          PTR_W         = 12;
    localparam int          NUM_PTR       = 3;
    localparam logic [1:0]  INDEX_PTR     = 2'h2;

    // Reset values
    localparam logic [7:0]  ACC_RESET     = 8'h00;
    localparam logic [11:0] PTR_RESET     = 12'h000;

    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b10,
        PH_Q4 = 2'b11
    } bmod_phase_t;

    typedef enum logic [1:0] {
        PEND_NONE = 2'b00,
        PEND_PTR  = 2'b01,
        PEND_COPY = 2'b10
    } bmod_pend_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } bmod_mem_req_t;

    typedef struct packed {
        logic neg;
        logic zero;
    } bmod_flags_t;

endpackage

// ### design/bmod_core.sv
// Overview of operation
// - Opcode 000100 ORs accumulator with file register, sets N and Z, one cycle.
// - Destination bit 0 writes accumulator, 1 writes back to the file register.
// - Access bit 0 uses the access bank, 1 takes upper address from bank selector.
// - Extended set with access bit 0 and address up to 95 uses indexed offset.
// - Four phases per cycle: decode, read file, process, write destination.
// - Pointer load puts a 12-bit literal into pointer 0 to 2 over two words.
// - First cycle writes literal upper part high, second cycle writes low byte.
// - Opcode 010100 copies file register to destination, sets N and Z, one cycle.
// - With access bit 1, the 8-bit file address selects any byte of the current 256-byte bank.
// - File-to-file copy uses words 1100 and 1111, two cycles, flags untouched.
// - File-to-file source and destination reach all 4096 bytes without banking.
// - File-to-file copy may use the accumulator as source or destination.
`timescale 1ns/1ps
`default_nettype none

module bmod_core (
    // Clock and reset
    input  wire logic                   CLK_I,
    input  wire logic                   RST_I,
    // Instruction fetch
    input  wire logic [15:0]            INSTR_I,
    input  wire logic                   INSTR_VALID_I,
    // Configuration
    input  wire logic [3:0]             BANK_SEL_I,
    input  wire logic                   EXT_EN_I,
    // Data memory
    input  wire logic [7:0]             MEM_RDATA_I,
    output bmod_pkg::bmod_mem_req_t     MEM_REQ_O,
    // Core state
    output logic [7:0]                  ACC_O,
    output bmod_pkg::bmod_flags_t       FLAGS_O,
    output logic [3*12-1:0]             PTRS_O,
    output bmod_pkg::bmod_phase_t       PHASE_O
);

    bmod_pkg::bmod_phase_t   phase_reg;
    bmod_pkg::bmod_phase_t   phase_next;
    bmod_pkg::bmod_pend_t    pend_reg;
    bmod_pkg::bmod_pend_t    pend_next;
    bmod_pkg::bmod_mem_req_t mem_reg;
    bmod_pkg::bmod_mem_req_t mem_next;
    bmod_pkg::bmod_flags_t   flags_reg;
    bmod_pkg::bmod_flags_t   flags_next;
    logic [15:0]             cur_reg;
    logic [7:0]              acc_reg;
    logic [7:0]              acc_next;
    logic [7:0]              data_reg;
    logic [1:0]              pidx_reg;
    logic [11:0]             ptr_reg [bmod_pkg::NUM_PTR];

    // Decode
    wire         in_q1      = (phase_reg == bmod_pkg::PH_Q1);
    wire         in_q3      = (phase_reg == bmod_pkg::PH_Q3);
    wire         in_q4      = (phase_reg == bmod_pkg::PH_Q4);
    wire [15:0]  fetched    = INSTR_VALID_I ? INSTR_I : bmod_pkg::OP_NOP;
    wire [15:0]  ins        = in_q1 ? fetched : cur_reg;
    wire         second     = (pend_reg != bmod_pkg::PEND_NONE);
    wire         is_or      = !second && (ins[15:10] == bmod_pkg::OP_OR_FILE);
    wire         is_copy_file_register    = !second && (ins[15:10] == bmod_pkg::OP_COPY_FILE);
    wire         is_byte    = is_or || is_copy_file_register;
    wire         is_ptr     = !second && (ins[15:8] == bmod_pkg::OP_LOAD_PTR);
    wire         is_copy1   = !second && (ins[15:12] == bmod_pkg::OP_COPY_FIRST);
    wire         is_copy2   = (pend_reg == bmod_pkg::PEND_COPY);
    wire         is_ptr2    = (pend_reg == bmod_pkg::PEND_PTR);
    wire         dbit       = ins[9];
    wire         abit       = ins[8];
    wire [7:0]   faddr      = ins[7:0];
    wire [1:0]   pidx       = ins[5:4];

    // Byte-oriented address generation
    wire         indexed    = EXT_EN_I && !abit && (faddr <= bmod_pkg::INDEX_LIMIT);
    wire [11:0]  index_addr = ptr_reg[bmod_pkg::INDEX_PTR] + {4'h0, faddr};
    wire [11:0]  access_addr = (faddr < bmod_pkg::ACCESS_SPLIT) ? {4'h0, faddr}
                                                                : {bmod_pkg::ACCESS_HIGH, faddr};
    wire [11:0]  bank_addr  = {BANK_SEL_I, faddr};
    wire [11:0]  byte_addr  = indexed ? index_addr : (abit ? bank_addr : access_addr);

    // Full-space copy addressing, accumulator as a special location
    wire [11:0]  far_addr   = ins[11:0];
    wire         far_is_acc = (far_addr == bmod_pkg::ACC_ADDR);
    wire         rd_start   = in_q1 && (is_byte || (is_copy1 && !far_is_acc));

    // Result of the process phase
    wire [7:0]   or_result  = acc_reg | MEM_RDATA_I;
    wire [7:0]   q3_result  = is_or ? or_result
                            : (is_copy1 && far_is_acc) ? acc_reg : MEM_RDATA_I;
    wire         capture    = in_q3 && (is_byte || is_copy1);

    // Phase sequencer, one instruction cycle every four clocks
    always_comb begin
        unique case (phase_reg)
            bmod_pkg::PH_Q1: phase_next = bmod_pkg::PH_Q2;
            bmod_pkg::PH_Q2: phase_next = bmod_pkg::PH_Q3;
            bmod_pkg::PH_Q3: phase_next = bmod_pkg::PH_Q4;
            bmod_pkg::PH_Q4: phase_next = bmod_pkg::PH_Q1;
        endcase
    end

    // Second-word tracking: set at the end of the first cycle of a two-word op
    always_comb begin
        pend_next = pend_reg;
        if (in_q4) begin
            if (is_ptr && (pidx < 2'(bmod_pkg::NUM_PTR))) begin
                pend_next = bmod_pkg::PEND_PTR;
            end else if (is_copy1) begin
                pend_next = bmod_pkg::PEND_COPY;
            end else begin
                pend_next = bmod_pkg::PEND_NONE;
            end
        end
    end

    // Memory strobes: read stands through Q2, write through Q4
    always_comb begin
        mem_next = mem_reg;
        if (in_q1) begin
            mem_next.rd   = rd_start;
            mem_next.addr = is_copy1 ? far_addr : byte_addr;
        end else if (phase_reg == bmod_pkg::PH_Q2) begin
            mem_next.rd = 1'b0;
        end else if (in_q3) begin
            if (is_byte && dbit) begin
                mem_next.wr    = 1'b1;
                mem_next.wdata = q3_result;
            end else if (is_copy2 && !far_is_acc) begin
                // Protected targets are not filtered; the program must avoid them
                mem_next.wr    = 1'b1;
                mem_next.addr  = far_addr;
                mem_next.wdata = data_reg;
            end
        end else begin
            mem_next.wr = 1'b0;
        end
    end

    // Accumulator and flags are committed in Q4
    always_comb begin
        acc_next   = acc_reg;
        flags_next = flags_reg;
        if (in_q4 && is_byte) begin
            if (!dbit) begin
                acc_next = data_reg;
            end
            flags_next.zero = (data_reg == 8'h00);
            flags_next.neg  = data_reg[7];
        end else if (in_q4 && is_copy2 && far_is_acc) begin
            acc_next = data_reg;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            phase_reg <= bmod_pkg::PH_Q1;
            pend_reg  <= bmod_pkg::PEND_NONE;
            mem_reg   <= '0;
            flags_reg <= '0;
            acc_reg   <= bmod_pkg::ACC_RESET;
            cur_reg   <= bmod_pkg::OP_NOP;
            data_reg  <= 8'h00;
            pidx_reg  <= 2'h0;
        end else begin
            phase_reg <= phase_next;
            pend_reg  <= pend_next;
            mem_reg   <= mem_next;
            flags_reg <= flags_next;
            acc_reg   <= acc_next;
            if (in_q1) begin
                cur_reg <= fetched;
            end
            if (capture) begin
                data_reg <= q3_result;
            end
            if (in_q4 && is_ptr) begin
                pidx_reg <= pidx;
            end
        end
    end

    // Indirect pointers; index 3 is not a pointer and is ignored
    genvar gi;
    generate
        for (gi = 0; gi < bmod_pkg::NUM_PTR; gi++) begin : g_ptr
            wire hi_wr = in_q4 && is_ptr && (pidx == 2'(gi));
            wire lo_wr = in_q4 && is_ptr2 && (pidx_reg == 2'(gi));
            always_ff @(posedge CLK_I) begin
                if (RST_I) begin
                    ptr_reg[gi] <= bmod_pkg::PTR_RESET;
                end else if (hi_wr) begin
                    ptr_reg[gi][11:8] <= ins[3:0];
                end else if (lo_wr) begin
                    ptr_reg[gi][7:0] <= ins[7:0];
                end
            end
            assign PTRS_O[gi*bmod_pkg::PTR_W +: bmod_pkg::PTR_W] = ptr_reg[gi];
        end
    endgenerate

    assign MEM_REQ_O = mem_reg;
    assign ACC_O     = acc_reg;
    assign FLAGS_O   = flags_reg;
    assign PHASE_O   = phase_reg;

    // Checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    a_phase_walk: assert property (in_q1 |=> phase_reg == bmod_pkg::PH_Q2 ##1
        phase_reg == bmod_pkg::PH_Q3 ##1 phase_reg == bmod_pkg::PH_Q4)
        else $error("Phases out of order");
    a_strobe_slots: assert property ((mem_reg.rd |-> phase_reg == bmod_pkg::PH_Q2)
        and (mem_reg.wr |-> phase_reg == bmod_pkg::PH_Q4))
        else $error("Memory strobe outside its phase");
    a_or_to_acc: assert property ((in_q3 && is_or && !dbit) |->
        ##2 acc_reg == ($past(acc_reg, 2) | $past(MEM_RDATA_I, 2)))
        else $error("OR result not in accumulator");
    a_flags_value: assert property ((in_q4 && is_byte) |=>
        flags_reg.zero == ($past(data_reg) == 8'h00) && flags_reg.neg == $past(data_reg[7]))
        else $error("Flags wrong after byte op");
    a_file_dest: assert property ((in_q3 && is_byte && dbit) |=>
        mem_reg.wr && mem_reg.addr == $past(mem_reg.addr) && mem_reg.wdata == data_reg)
        else $error("Write-back to file missing");
    a_bank_address: assert property ((in_q1 && is_byte && abit) |=>
        mem_reg.rd && mem_reg.addr == {$past(BANK_SEL_I), $past(INSTR_I[7:0])})
        else $error("Banked address wrong");
    a_index_address: assert property ((in_q1 && is_byte && indexed) |=>
        mem_reg.addr == $past(ptr_reg[2]) + {4'h0, $past(INSTR_I[7:0])})
        else $error("Indexed address wrong");
    a_ptr_high: assert property ((in_q4 && is_ptr && pidx == 2'h1) |=>
        ptr_reg[1][11:8] == $past(ins[3:0]))
        else $error("Pointer high part not loaded");
    a_copy_flags: assert property ((is_copy1 || is_copy2) |=> $stable(flags_reg))
        else $error("Copy changed flags");
    a_copy_dest: assert property ((in_q3 && is_copy2 && !far_is_acc) |=>
        mem_reg.wr && mem_reg.addr == $past(ins[11:0]) && mem_reg.wdata == $past(data_reg))
        else $error("Copy destination write wrong");

    c_or_to_file: cover property (in_q3 && is_or && dbit);
    c_ptr_load:   cover property (in_q4 && is_ptr2);
    c_copy_acc:   cover property (in_q4 && is_copy2 && far_is_acc);

endmodule

`default_nettype wire

// ### tb/bmod_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module bmod_mem_model (
    // Clock
    input  wire logic                   clk_i,
    // Request from the core
    input  wire bmod_pkg::bmod_mem_req_t req_i,
    // Read data back to the core
    output logic [7:0]                  rdata_o
);
    logic [7:0] mem [4096];

    initial rdata_o = 8'h00;

    // Data is only valid in the cycle after rd; otherwise it toggles so stale reads show up
    always @(posedge clk_i) begin
        if (req_i.wr) begin
            mem[req_i.addr] <= req_i.wdata;
        end
        rdata_o <= req_i.rd ? mem[req_i.addr] : ~rdata_o;
    end
endmodule

`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam logic [11:0] ACC = bmod_pkg::ACC_ADDR;
    logic                    clk_i = 1'b0;
    logic                    rst_i = 1'b1;
    logic                    valid_i = 1'b0;
    logic                    ext_i = 1'b0;
    logic [15:0]             instr_i = 16'h0000;
    logic [3:0]              bank_i = 4'h0;
    logic [7:0]              rdata;
    logic [7:0]              acc;
    logic [35:0]             ptrs;
    bmod_pkg::bmod_mem_req_t req;
    bmod_pkg::bmod_flags_t   flg;
    bmod_pkg::bmod_phase_t   ph;
    logic [7:0]              racc;
    logic [1:0]              rflg;
    logic [35:0]             rptr;
    logic [7:0]              rmem [4096];
    int                      n_errors = 0;
    int                      cmp_count = 0;

    bmod_core u_bmod_core (.CLK_I(clk_i), .RST_I(rst_i), .INSTR_I(instr_i),
        .INSTR_VALID_I(valid_i), .BANK_SEL_I(bank_i), .EXT_EN_I(ext_i),
        .MEM_RDATA_I(rdata), .MEM_REQ_O(req), .ACC_O(acc), .FLAGS_O(flg),
        .PTRS_O(ptrs), .PHASE_O(ph));
    bmod_mem_model u_bmod_mem_model (.clk_i(clk_i), .req_i(req), .rdata_o(rdata));

    initial forever #2.5 clk_i = ~clk_i;

    task chk(input string nm, input logic [35:0] s, input logic [35:0] e);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    task report_and_stop;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    function logic [11:0] eff(input logic a, input logic [7:0] f);
        if (a) return {bank_i, f};
        if (ext_i && f <= 8'h5F) return rptr[35:24] + {4'h0, f};
        return {(f < 8'h60) ? 4'h0 : 4'hF, f};
    endfunction

    // Entered at a falling edge in Q1; leaves at the next Q1 with state settled
    task word(input logic [15:0] w, input logic erd, input logic ewr,
              input logic [11:0] ra, input logic [11:0] wa, input logic [7:0] wd);
        instr_i = w;
        valid_i = 1'b1;
        chk("phase", ph, bmod_pkg::PH_Q1);
        @(negedge clk_i);
        valid_i = 1'b0;
        instr_i = 16'($urandom);
        chk("rd", req.rd, erd);
        if (erd) chk("rd addr", req.addr, ra);
        repeat (2) @(negedge clk_i);
        chk("wr", req.wr, ewr);
        if (ewr) chk("wr addr data", {req.addr, req.wdata}, {wa, wd});
        @(negedge clk_i);
        chk("acc", acc, racc);
        chk("flags", flg, rflg);
        chk("ptrs", ptrs, rptr);
    endtask

    task byteop(input logic cp, input logic d, input logic a, input logic [7:0] f);
        logic [11:0] ea;
        logic [7:0]  r;
        ea = eff(a, f);
        // Accumulator alias inside a bank is left out: its read path is not modelled
        if (ea == ACC) f ^= 8'h01;
        ea = eff(a, f);
        r = cp ? rmem[ea] : (racc | rmem[ea]);
        if (d) rmem[ea] = r;
        else racc = r;
        rflg = {r[7], r == 8'h00};
        word({cp ? bmod_pkg::OP_COPY_FILE : bmod_pkg::OP_OR_FILE, d, a, f},
             1'b1, d, ea, ea, r);
    endtask

    task copy(input logic [11:0] s, input logic [11:0] dd);
        logic [7:0] v;
        v = (s == ACC) ? racc : rmem[s];
        word({bmod_pkg::OP_COPY_FIRST, s}, s != ACC, 1'b0, s, 12'h000, 8'h00);
        if (dd == ACC) racc = v;
        else rmem[dd] = v;
        word({bmod_pkg::OP_SECOND, dd}, 1'b0, dd != ACC, 12'h000, dd, v);
    endtask

    task ldptr(input logic [1:0] i, input logic [11:0] k);
        if (i != 2'd3) rptr[i * 12 + 8 +: 4] = k[11:8];
        word({bmod_pkg::OP_LOAD_PTR, 2'b00, i, k[11:8]},
             1'b0, 1'b0, 12'h000, 12'h000, 8'h00);
        if (i == 2'd3) return;
        rptr[i * 12 +: 8] = k[7:0];
        word({8'hF0, k[7:0]}, 1'b0, 1'b0, 12'h000, 12'h000, 8'h00);
    endtask

    initial begin
        #20000;
        n_errors++;
        report_and_stop;
    end

    initial begin
        void'($urandom(30));
        for (int i = 0; i < 4096; i++) rmem[i] = 8'($urandom);
        rmem[0] = 8'h00;
        rmem[1] = 8'h80;
        for (int i = 0; i < 4096; i++) u_bmod_mem_model.mem[i] = rmem[i];
        racc = 8'h00;
        rflg = 2'b00;
        rptr = 36'h0;
        repeat (2) @(negedge clk_i);
        chk("reset", {acc, flg, ph, req}, 36'h0);
        rst_i = 1'b0;
        ldptr(2'd0, 12'hFFF);
        ldptr(2'd1, 12'h000);
        ldptr(2'd3, 12'h5A5);
        ldptr(2'd2, 12'h3AB);
        byteop(1'b1, 1'b0, 1'b0, 8'h00);
        byteop(1'b1, 1'b0, 1'b0, 8'h01);
        byteop(1'b0, 1'b1, 1'b1, 8'hFF);
        copy(12'hFFF, ACC);
        copy(ACC, 12'h000);
        copy(12'h000, 12'hEFF);
        ext_i = 1'b1;
        byteop(1'b0, 1'b0, 1'b0, 8'h5F);
        byteop(1'b1, 1'b1, 1'b0, 8'h60);
        for (int n = 0; n < 80; n++) begin
            bank_i = 4'($urandom);
            ext_i = 1'($urandom);
            // Copy targets stay below the core's control bytes, apart from the accumulator
            if ($urandom_range(3) == 0) begin
                copy(12'($urandom),
                     ($urandom_range(7) == 0) ? ACC : 12'($urandom_range(12'hEFF)));
            end else begin
                byteop(1'($urandom), 1'($urandom), 1'($urandom), 8'($urandom));
            end
        end
        // Q1 without valid must act as a no-operation even on a live opcode
        instr_i = {bmod_pkg::OP_COPY_FILE, 2'b00, 8'h00};
        valid_i = 1'b0;
        @(negedge clk_i);
        chk("nop rd", req.rd, 1'b0);
        repeat (3) @(negedge clk_i);
        chk("nop wr", req.wr, 1'b0);
        @(negedge clk_i);
        chk("nop acc flags", {acc, flg}, {racc, rflg});
        report_and_stop;
    end
endmodule

`default_nettype wire
